// [mmtc_top.sv]
// motor mode timer: prescaled 16-bit counter, capture, three compares, APB registers
//
// What this block does
// - debug enable bit drives internal debug signal onto debug pin, else pin released.
// - read-only overflow bit in second control register shows the timer has overflowed.
// - with capture-on-overload enabled, an overload event copies the count into capture.
// - writing one to software capture bit copies the count; zero does nothing.
// - with capture-on-position enabled, each position event loads capture with the count.
// - three-bit clock select picks system_clock divided by 8,16,32,64 or 128.
// - with reset-on-timer-3 enabled, a timer 3 event clears the count.
// - with reset-on-overload enabled, an overload event clears the count.
// - writing one to software reset bit clears the count; zero does nothing.
// - with reset-on-position enabled, each position event clears the count.
// - enable bit runs the timer when one and holds it when zero.
// - sixteen-bit read-only capture register holds the last captured count.
// - three sixteen-bit read/write compare registers hold values matched against the timer.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module mmtc_top #(
	parameter int CNT_W = mmtc_pkg::CNT_W
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_b_i,
	input  wire logic                        ce_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [mmtc_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]                 pwdata_i,
	output logic      [31:0]                 prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	input  wire logic                        overload_i,
	input  wire logic                        position_det_i,
	input  wire logic                        timer3_evt_i,
	output logic      [2:0]                  match_o,
	output logic                             debug_port_pin_o,
	output logic                             debug_port_pin_oe_b_o,
	output logic                             irq_o
);
	localparam int NIN = 3;

	// synchronisers: stage one feeds stage two only
	logic [NIN-1:0]   sy1_r, sy2_r, sy3_r, lvl_r;
	logic [NIN-1:0]   lvl_nxt, rise;
	logic [mmtc_pkg::PRE_W-1:0] pre_r, pre_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt, cap_r, cap_nxt;
	logic [CNT_W-1:0] cmp_r [3], cmp_nxt [3];
	logic [7:0]       ca_r, ca_nxt, cb_r, cb_nxt;
	logic [mmtc_pkg::IRQ_W-1:0] sts_r, sts_nxt, ien_r, ien_nxt;
	logic [2:0]       match_r, match_nxt;
	logic             tick_r, tick_nxt;
	logic             dbg_r, dbg_nxt, dboe_r, dboe_nxt, irq_r, irq_nxt;
	logic [31:0]      rd_r, rd_nxt;
	logic             rdy_r, rdy_nxt, err_r, err_nxt;
	logic             tick, wr, setup, hit, do_clr, do_cap, wrap, sw_rst, sw_cap;
	logic [31:0]      rdata;
	logic [13:0]      idx;
	logic [CNT_W-1:0] cap_src;

	assign idx   = paddr_i[15:2];
	assign setup = psel_i && !penable_i && !rdy_r;
	assign wr    = psel_i && penable_i && rdy_r && pwrite_i && !err_r;

	// clock select: reserved codes give no tick at all
	always_comb begin
		case (ca_r[mmtc_pkg::CA_CLKSEL_LSB +: 3])
			mmtc_pkg::SEL_DIV8:   tick = &pre_r[2:0];
			mmtc_pkg::SEL_DIV16:  tick = &pre_r[3:0];
			mmtc_pkg::SEL_DIV32:  tick = &pre_r[4:0];
			mmtc_pkg::SEL_DIV64:  tick = &pre_r[5:0];
			mmtc_pkg::SEL_DIV128: tick = &pre_r[6:0];
			default:              tick = 1'b0;
		endcase
	end

	// read mux for the current setup address
	always_comb begin
		rdata = 32'h0000_0000;
		hit   = 1'b1;
		case (idx)
			mmtc_pkg::IDX_CTRL_FIRST:  rdata[7:0] = ca_r & ~(8'h01 << mmtc_pkg::CA_RST_SW);
			mmtc_pkg::IDX_CTRL_SECOND: rdata[7:0] = cb_r;
			mmtc_pkg::IDX_CAPTURE:     rdata[CNT_W-1:0] = cap_r;
			mmtc_pkg::IDX_MATCH_ONE:   rdata[CNT_W-1:0] = cmp_r[0];
			mmtc_pkg::IDX_MATCH_TWO:   rdata[CNT_W-1:0] = cmp_r[1];
			mmtc_pkg::IDX_MATCH_THREE: rdata[CNT_W-1:0] = cmp_r[2];
			mmtc_pkg::IDX_IRQ_STATUS:  rdata[mmtc_pkg::IRQ_W-1:0] = sts_r;
			mmtc_pkg::IDX_IRQ_CLEAR:   rdata = 32'h0000_0000;
			mmtc_pkg::IDX_IRQ_ENABLE:  rdata[mmtc_pkg::IRQ_W-1:0] = ien_r;
			default:                   hit = 1'b0;
		endcase
	end

	always_comb begin
		// a rising event counts once stages two and three agree on a new high level
		lvl_nxt = lvl_r;
		rise    = '0;
		for (int i = 0; i < NIN; i++) begin
			if (sy2_r[i] == sy3_r[i] && sy3_r[i] != lvl_r[i]) begin
				lvl_nxt[i] = sy3_r[i];
				rise[i]    = sy3_r[i];
			end
		end

		ca_nxt  = ca_r;
		cb_nxt  = cb_r;
		ien_nxt = ien_r;
		for (int k = 0; k < 3; k++) begin
			cmp_nxt[k] = cmp_r[k];
		end
		sw_rst  = 1'b0;
		sw_cap  = 1'b0;
		sts_nxt = sts_r;
		if (wr) begin
			case (idx)
				mmtc_pkg::IDX_CTRL_FIRST: begin
					ca_nxt = pwdata_i[7:0] & ~(8'h01 << mmtc_pkg::CA_RST_SW);
					sw_rst = pwdata_i[mmtc_pkg::CA_RST_SW];
				end
				mmtc_pkg::IDX_CTRL_SECOND: begin
					// overflow bit is read-only, write-only capture bit never stored
					cb_nxt = {pwdata_i[7], 3'h0, pwdata_i[3], 1'b0, pwdata_i[1], 1'b0};
					sw_cap = pwdata_i[mmtc_pkg::CB_CAP_SW];
				end
				mmtc_pkg::IDX_MATCH_ONE:   cmp_nxt[0] = pwdata_i[CNT_W-1:0];
				mmtc_pkg::IDX_MATCH_TWO:   cmp_nxt[1] = pwdata_i[CNT_W-1:0];
				mmtc_pkg::IDX_MATCH_THREE: cmp_nxt[2] = pwdata_i[CNT_W-1:0];
				mmtc_pkg::IDX_IRQ_CLEAR:   sts_nxt = sts_r & ~pwdata_i[mmtc_pkg::IRQ_W-1:0];
				mmtc_pkg::IDX_IRQ_ENABLE:  ien_nxt = pwdata_i[mmtc_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end

		// prescaler runs free so a tick phase never depends on the enable
		pre_nxt = pre_r + 1'b1;

		do_clr = sw_rst
			|| (ca_r[mmtc_pkg::CA_RST_POS] && rise[1])
			|| (ca_r[mmtc_pkg::CA_RST_OVL] && rise[0])
			|| (ca_r[mmtc_pkg::CA_RST_T3] && rise[2]);
		do_cap = sw_cap
			|| (cb_r[mmtc_pkg::CB_CAP_POS] && rise[1])
			|| (cb_r[mmtc_pkg::CB_CAP_OVL] && rise[0]);

		// capture sees the count before a same-cycle clear
		cap_src = cnt_r;
		cap_nxt = do_cap ? cap_src : cap_r;

		wrap    = 1'b0;
		cnt_nxt = cnt_r;
		if (do_clr) begin
			cnt_nxt = mmtc_pkg::CNT_RESET;
		end else if (ca_r[mmtc_pkg::CA_ENABLE] && tick) begin
			cnt_nxt = cnt_r + 1'b1;
			wrap    = &cnt_r;
		end

		// hardware set wins over a clear written in the same cycle
		if (wrap) begin
			sts_nxt[mmtc_pkg::IRQ_OVERFLOW] = 1'b1;
		end
		if (do_cap) begin
			sts_nxt[mmtc_pkg::IRQ_CAPTURE] = 1'b1;
		end
		for (int k = 0; k < 3; k++) begin
			// a pulse only when the count moves onto the value, not while it sits there
			match_nxt[k] = (cnt_nxt == cmp_nxt[k]) && (cnt_nxt != cnt_r);
			if (match_nxt[k]) begin
				sts_nxt[mmtc_pkg::IRQ_MATCH_LSB + k] = 1'b1;
			end
		end
		cb_nxt[mmtc_pkg::CB_OVERFLOW] = sts_nxt[mmtc_pkg::IRQ_OVERFLOW];

		tick_nxt = tick && ca_r[mmtc_pkg::CA_ENABLE];
		dbg_nxt  = cb_r[mmtc_pkg::CB_DEBUG] ? tick_r : 1'b0;
		dboe_nxt = !cb_r[mmtc_pkg::CB_DEBUG];
		irq_nxt  = |(sts_nxt & ien_nxt);

		// zero-wait slave: answer is prepared in setup, ready in first access cycle
		rdy_nxt = setup;
		err_nxt = setup ? !hit : 1'b0;
		rd_nxt  = (setup && !pwrite_i && hit) ? rdata : 32'h0000_0000;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sy1_r    <= '0;
			sy2_r    <= '0;
			sy3_r    <= '0;
			lvl_r    <= '0;
			pre_r    <= '0;
			cnt_r    <= mmtc_pkg::CNT_RESET;
			cap_r    <= mmtc_pkg::CNT_RESET;
			for (int k = 0; k < 3; k++) begin
				cmp_r[k] <= mmtc_pkg::CNT_RESET;
			end
			ca_r     <= mmtc_pkg::CTRL_RESET;
			cb_r     <= mmtc_pkg::CTRL_RESET;
			sts_r    <= '0;
			ien_r    <= '0;
			match_r  <= 3'h0;
			tick_r   <= 1'b0;
			dbg_r    <= 1'b0;
			dboe_r   <= 1'b1;
			irq_r    <= 1'b0;
			rd_r     <= 32'h0000_0000;
			rdy_r    <= 1'b0;
			err_r    <= 1'b0;
		end else if (ce_i) begin
			sy1_r    <= {timer3_evt_i, position_det_i, overload_i};
			sy2_r    <= sy1_r;
			sy3_r    <= sy2_r;
			lvl_r    <= lvl_nxt;
			pre_r    <= pre_nxt;
			cnt_r    <= cnt_nxt;
			cap_r    <= cap_nxt;
			for (int k = 0; k < 3; k++) begin
				cmp_r[k] <= cmp_nxt[k];
			end
			ca_r     <= ca_nxt;
			cb_r     <= cb_nxt;
			sts_r    <= sts_nxt;
			ien_r    <= ien_nxt;
			match_r  <= match_nxt;
			tick_r   <= tick_nxt;
			dbg_r    <= dbg_nxt;
			dboe_r   <= dboe_nxt;
			irq_r    <= irq_nxt;
			rd_r     <= rd_nxt;
			rdy_r    <= rdy_nxt;
			err_r    <= err_nxt;
		end
	end

	assign prdata_o              = rd_r;
	assign pready_o              = rdy_r;
	assign pslverr_o             = err_r;
	assign match_o               = match_r;
	assign debug_port_pin_o      = dbg_r;
	assign debug_port_pin_oe_b_o = dboe_r;
	assign irq_o                 = irq_r;
endmodule

// [mmtc_pkg.sv]
// constants for the motor mode timer with capture and compare
package mmtc_pkg;
	localparam int          CNT_W          = 16;
	localparam int          PRE_W          = 7;
	localparam int          ADDR_W         = 16;
	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_CTRL_FIRST  = 14'h1FA4;
	localparam logic [13:0] IDX_CTRL_SECOND = 14'h1FA5;
	localparam logic [13:0] IDX_CAPTURE     = 14'h1FA6;
	localparam logic [13:0] IDX_MATCH_ONE   = 14'h1FA8;
	localparam logic [13:0] IDX_MATCH_TWO   = 14'h1FAA;
	localparam logic [13:0] IDX_MATCH_THREE = 14'h1FAC;
	localparam logic [13:0] IDX_IRQ_STATUS  = 14'h1FF0;
	localparam logic [13:0] IDX_IRQ_CLEAR   = 14'h1FF1;
	localparam logic [13:0] IDX_IRQ_ENABLE  = 14'h1FF2;
	// first control register fields
	localparam int          CA_ENABLE      = 0;
	localparam int          CA_RST_POS     = 1;
	localparam int          CA_RST_SW      = 2;
	localparam int          CA_RST_OVL     = 3;
	localparam int          CA_RST_T3      = 4;
	localparam int          CA_CLKSEL_LSB  = 5;
	// second control register fields
	localparam int          CB_CAP_POS     = 1;
	localparam int          CB_CAP_SW      = 2;
	localparam int          CB_CAP_OVL     = 3;
	localparam int          CB_OVERFLOW    = 5;
	localparam int          CB_DEBUG       = 7;
	// clock select codes
	localparam logic [2:0]  SEL_DIV8       = 3'h0;
	localparam logic [2:0]  SEL_DIV16      = 3'h2;
	localparam logic [2:0]  SEL_DIV32      = 3'h4;
	localparam logic [2:0]  SEL_DIV64      = 3'h6;
	localparam logic [2:0]  SEL_DIV128     = 3'h1;
	// interrupt status bits
	localparam int          IRQ_W          = 5;
	localparam int          IRQ_OVERFLOW   = 0;
	localparam int          IRQ_CAPTURE    = 1;
	localparam int          IRQ_MATCH_LSB  = 2;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [15:0] CNT_RESET      = 16'h0000;
endpackage

// [mmtc_evt_model.sv]
// far-side event sources: bit 0 overload, bit 1 position, bit 2 timer 3
`timescale 1ns/100ps
module mmtc_evt_model (
	input  wire logic       core_clk_i,
	input  wire logic [2:0] fire_i,
	output logic      [2:0] line_o
);
	// a line stays high for 6 cycles so it survives the synchroniser
	int hold_r [3] = '{0, 0, 0};
	always @(posedge core_clk_i) begin
		for (int k = 0; k < 3; k++) begin
			hold_r[k] <= fire_i[k] ? 6 : (hold_r[k] > 0 ? hold_r[k] - 1 : 0);
		end
	end
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			line_o[k] = hold_r[k] > 0;
		end
	end
endmodule

// [mmtc_sva.sv]
// port checks for the motor mode timer
`timescale 1ns/100ps
module mmtc_sva (
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [2:0]  match_o,
	input wire logic        debug_port_pin_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	property single(b);
		b |=> !b;
	endproperty
	a_setup_gets_ready: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
	a_ready_single: assert property (single(pready_o)) else $error("long ready");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("stray error");
	a_idle_data_zero: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray data");
	a_upper_bits_zero: assert property (pready_o |-> prdata_o[31:16] == 16'h0) else $error("high bits");
	a_tick_spacing: assert property (debug_port_pin_o |=> !debug_port_pin_o [*7]) else $error("tick gap");
	a_match1_single: assert property (single(match_o[0])) else $error("match 1 long");
	a_match2_single: assert property (single(match_o[1])) else $error("match 2 long");
	a_match3_single: assert property (single(match_o[2])) else $error("match 3 long");
	c_error: cover property (pslverr_o);
	c_match: cover property (match_o == 3'h3);
	c_tick: cover property (debug_port_pin_o);
endmodule
bind mmtc_top mmtc_sva u_sva (.*);

// [mmtc_top_tb.sv]
// self-checking bench for the motor mode timer
`timescale 1ns/100ps
module mmtc_top_tb;
	logic        core_clk_i = 1'h0, rst_b_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
	logic        ce_i = 1'h1, pready_o, pslverr_o, debug_port_pin_o, debug_port_pin_oe_b_o, irq_o, errv;
	logic [15:0] paddr_i = 16'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rdv;
	logic [2:0]  fire = 3'h0, match_o;
	wire logic   overload_i, position_det_i, timer3_evt_i;
	int          n_mismatch = 0, num_checks = 0;
	always #5 core_clk_i = ~core_clk_i;
	mmtc_top DUT (.*);
	mmtc_evt_model u_evt (.core_clk_i(core_clk_i), .fire_i(fire), .line_o({timer3_evt_i, position_det_i, overload_i}));
	task automatic wrap_up();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fail();
		n_mismatch++;
		$display("BAD %0t wait ran out", $time);
		wrap_up();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// request held until pready is sampled high, released after that edge
	task automatic apb(input logic [13:0] idx, input logic wr, input logic [31:0] wd);
		int n;
		psel_i <= 1'h1;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'h0};
		pwdata_i <= wd;
		@(posedge core_clk_i);
		penable_i <= 1'h1;
		// ready is looked at mid-cycle, where it has settled, then taken at the next rising edge
		n = 0;
		@(negedge core_clk_i);
		while (pready_o !== 1'h1 && n < 16) begin
			@(posedge core_clk_i);
			@(negedge core_clk_i);
			n++;
		end
		if (pready_o !== 1'h1) fail();
		rdv = prdata_o;
		errv = pslverr_o;
		@(posedge core_clk_i);
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [13:0] idx, input logic [31:0] e);
		apb(idx, 1'h0, 32'h0);
		chk(rdv, e);
	endtask
	task automatic s_regs();
		rd(mmtc_pkg::IDX_CTRL_FIRST, 32'h0);
		rd(mmtc_pkg::IDX_CTRL_SECOND, 32'h0);
		for (int k = 0; k < 3; k++) begin
			apb(14'(mmtc_pkg::IDX_MATCH_ONE + 2 * k), 1'h1, 32'hFFFFA5C3 + k);
			rd(14'(mmtc_pkg::IDX_MATCH_ONE + 2 * k), 32'h0000A5C3 + k);
		end
		apb(mmtc_pkg::IDX_CAPTURE, 1'h1, 32'h1234);
		rd(mmtc_pkg::IDX_CAPTURE, 32'h0);
		apb(14'h0100, 1'h0, 32'h0);
		chk(32'(errv), 32'h1);
	endtask
	// edges between two debug pulses; 300 means none came
	task automatic gap(output int g);
		for (int p = 0; p < 2; p++) begin
			g = 0;
			do begin
				@(negedge core_clk_i);
				g++;
			end while (debug_port_pin_o !== 1'h1 && g < 300);
		end
		@(posedge core_clk_i);
	endtask
	task automatic s_clk();
		logic [7:0] ctl [7] = '{8'h01, 8'h41, 8'h81, 8'hC1, 8'h21, 8'h61, 8'h00};
		int div [7] = '{8, 16, 32, 64, 128, 300, 300};
		int g;
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'h80);
		tick(2);
		chk(32'(debug_port_pin_oe_b_o), 32'h0);
		for (int k = 0; k < 7; k++) begin
			apb(mmtc_pkg::IDX_CTRL_FIRST, 1'h1, 32'(ctl[k]));
			gap(g);
			chk(g, div[k]);
		end
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'h0);
		tick(2);
		chk(32'(debug_port_pin_oe_b_o), 32'h1);
	endtask
	// clear and start at fc/8, stop right after the count reaches 3
	task automatic run3(output logic [2:0] m);
		int n;
		apb(mmtc_pkg::IDX_CTRL_FIRST, 1'h1, 32'h05);
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (match_o === 3'h0 && n < 300);
		if (n >= 300) fail();
		m = match_o;
		@(posedge core_clk_i);
		apb(mmtc_pkg::IDX_CTRL_FIRST, 1'h1, 32'h00);
	endtask
	task automatic s_match();
		logic [2:0] m;
		apb(mmtc_pkg::IDX_MATCH_ONE, 1'h1, 32'h3);
		apb(mmtc_pkg::IDX_MATCH_TWO, 1'h1, 32'h3);
		apb(mmtc_pkg::IDX_MATCH_THREE, 1'h1, 32'h4);
		run3(m);
		chk(32'(m), 32'h3);
		tick(40);
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'h04);
		rd(mmtc_pkg::IDX_CAPTURE, 32'h3);
		apb(mmtc_pkg::IDX_CTRL_FIRST, 1'h1, 32'h04);
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'h04);
		rd(mmtc_pkg::IDX_CAPTURE, 32'h0);
	endtask
	// capture after the event, then after a software capture
	task automatic ev(input logic [2:0] f, input logic [7:0] a, b, input logic [31:0] e1, e2);
		logic [2:0] m;
		run3(m);
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'(b));
		apb(mmtc_pkg::IDX_CTRL_FIRST, 1'h1, 32'(a));
		fire <= f;
		@(posedge core_clk_i);
		fire <= 3'h0;
		tick(12);
		rd(mmtc_pkg::IDX_CAPTURE, e1);
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'h04);
		rd(mmtc_pkg::IDX_CAPTURE, e2);
	endtask
	task automatic s_irq();
		apb(mmtc_pkg::IDX_IRQ_CLEAR, 1'h1, 32'h1F);
		rd(mmtc_pkg::IDX_IRQ_STATUS, 32'h0);
		apb(mmtc_pkg::IDX_CTRL_SECOND, 1'h1, 32'h04);
		rd(mmtc_pkg::IDX_IRQ_STATUS, 32'h2);
		chk(32'(irq_o), 32'h0);
		apb(mmtc_pkg::IDX_IRQ_ENABLE, 1'h1, 32'h2);
		tick(2);
		chk(32'(irq_o), 32'h1);
		apb(mmtc_pkg::IDX_IRQ_CLEAR, 1'h1, 32'h2);
		tick(2);
		chk(32'(irq_o), 32'h0);
	endtask
	initial begin
		tick(2);
		rst_b_i <= 1'h1;
		s_regs();
		s_clk();
		s_match();
		ev(3'h4, 8'h10, 8'h00, 32'h0, 32'h0);
		ev(3'h2, 8'h02, 8'h02, 32'h3, 32'h0);
		ev(3'h1, 8'h08, 8'h08, 32'h3, 32'h0);
		ev(3'h1, 8'h00, 8'h00, 32'h0, 32'h3);
		ev(3'h4, 8'h00, 8'h00, 32'h3, 32'h3);
		s_irq();
		wrap_up();
	end
endmodule
